// ==== logic/lvm_pkg.sv ====
// Package for the low-voltage monitor: register map, bit fields, reset values and timing.
// Assumes a 250 MHz system clock; used by every file of the block.
package lvm_pkg;
    // Clock
    localparam int unsigned CLK_PERIOD_NS = 4;

    // Times, in ns; both are least times and round up
    localparam int unsigned FLAG_DELAY_NS    = 60000;
    localparam int unsigned SETTLE_NS        = 150000;
    localparam int unsigned FLAG_DELAY_CYC   = (FLAG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_CYC       = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W            = 16;

    // Register byte addresses
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_IRQ  = 12'h004;

    // low_voltage_control fields
    localparam int unsigned CTRL_SEL_LSB = 0;
    localparam int unsigned CTRL_SEL_W   = 3;
    localparam int unsigned CTRL_REF_BIT = 3;
    localparam int unsigned CTRL_EN_BIT  = 4;
    localparam int unsigned CTRL_DET_BIT = 5;
    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [2:0]  SEL_EXTERNAL = 3'h0;

    // Interrupt control fields
    localparam int unsigned IRQ_GIE_BIT    = 0;
    localparam int unsigned IRQ_LVIEN_BIT  = 1;
    localparam int unsigned IRQ_MFE_BIT    = 2;
    localparam int unsigned IRQ_LVREQ_BIT  = 3;
    localparam int unsigned IRQ_MFF_BIT    = 4;
    localparam int unsigned IRQ_SETTLE_BIT = 5;
    localparam logic [7:0]  IRQ_RESET      = 8'h00;
endpackage

// ==== logic/lvm_sync.sv ====
// Two-stage synchroniser for one asynchronous level.
// Assumes the input is a raw comparator or pin level.
`timescale 1ns/100ps
module lvm_sync
    import lvm_pkg::*;
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // Level
    input  wire logic asyncIn,
    output logic      syncOut
);
    typedef struct packed {
        logic stage1;
        logic stage2;
    } lvm_sync_t;

    lvm_sync_t state_reg;
    lvm_sync_t state_next;

    // First stage feeds only the second stage
    always_comb begin
        state_next        = state_reg;
        state_next.stage1 = asyncIn;
        state_next.stage2 = state_reg.stage1;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign syncOut = state_reg.stage2;
endmodule // lvm_sync

// ==== logic/lvm_delay.sv ====
// Run-and-hold delay counter: done rises once run has stood for limit cycles.
// Assumes run is a synchronous level; dropping run restarts the count.
`timescale 1ns/100ps
module lvm_delay
    import lvm_pkg::*;
(
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst,
    // Control
    input  wire logic             run,
    input  wire logic [CNT_W-1:0] limit,
    // Status
    output logic                  done,
    output logic                  donePulse
);
    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic             done;
        logic             pulse;
    } lvm_delay_t;

    lvm_delay_t state_reg;
    lvm_delay_t state_next;

    always_comb begin
        state_next       = state_reg;
        state_next.pulse = 1'b0;
        if (!run) begin
            state_next.count = '0;
            state_next.done  = 1'b0;
        end else if (!state_reg.done) begin
            state_next.count = state_reg.count + 1'b1;
            if (state_next.count >= limit) begin
                state_next.done  = 1'b1;
                state_next.pulse = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign done      = state_reg.done;
    assign donePulse = state_reg.pulse;
endmodule // lvm_delay

// ==== logic/lvm_top.sv ====
// Low-voltage monitor control: control register, delayed request flag, combined interrupt and wake-up.
// Assumes an APB master on mclk, an analog comparator outside, and a core that stacks the PC.
//
// How it works
// - Low detection sets the low-voltage request flag
// - Vector needs all enables, stack room, request
// - Service clears global enable, combined flag only
// - Rising request flag wakes from sleep/idle
// - Set request flag holds until software clears it; service leaves it
// - Interrupt entry pushes only the PC
// - Reenabling return sets global enable; plain leaves
// - Bits 7,6 zero; status read-only; reset zero
// - Bit 5 reads detected low voltage
// - Bit 4 switches detector on or off
// - Reference on: detector, reset monitor, bit 3
// - Code 000 external input, others supply levels
// - Detector off during sleep mode
// - Request flag set after flag delay
// - Repeated status toggles restart the delay
// - Low-voltage request wakes from idle
// - Combined flag set by any included source
`timescale 1ns/100ps
module lvm_top
    import lvm_pkg::*;
#(
    parameter int unsigned FLAG_CYCLES   = FLAG_DELAY_CYC,
    parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
)
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Analog detector
    input  wire logic        comparatorLow,
    output logic             detectorOn,
    output logic             referenceOn,
    output logic [2:0]       thresholdSel,
    output logic             senseExternal,
    // Core and power manager
    input  wire logic        lowResetOn,
    input  wire logic        sleepMode,
    input  wire logic        idleMode,
    input  wire logic        stackFull,
    input  wire logic        serviceAck,
    input  wire logic        retInstr,
    input  wire logic        retReenable,
    input  wire logic        otherSourceRise,
    output logic             vectorRequest,
    output logic             pushPcOnly,
    output logic             wakeUp
);
    typedef struct packed {
        logic [2:0]  sel;
        logic        refBit;
        logic        enBit;
        logic        gie;
        logic        lvIrqEn;
        logic        mfe;
        logic        lvReq;
        logic        mff;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic        detOn;
        logic        refOn;
        logic        vecReq;
        logic        pushPc;
        logic        wake;
        logic        senseExt;
        logic [CNT_W-1:0] detRun;
    } lvm_state_t;

    lvm_state_t state_reg;
    lvm_state_t state_next;

    logic             lowSync;
    logic             detected;
    logic             flagDone;
    logic             flagRise;
    logic             settled;
    logic             setupPhase;
    logic             writeTaken;
    logic             hitCtrl;
    logic             hitIrq;
    logic [7:0]       ctrlRead;
    logic [7:0]       irqRead;
    logic [CNT_W-1:0] flagLimit;
    logic [CNT_W-1:0] settleLimit;

    assign flagLimit   = CNT_W'(FLAG_CYCLES);
    assign settleLimit = CNT_W'(SETTLE_CYCLES);

    // Comparator output is asynchronous to mclk
    lvm_sync u_sync (
        .mclk    (mclk),
        .rst     (rst),
        .asyncIn (comparatorLow),
        .syncOut (lowSync)
    );

    // Status reads zero whenever the detector is powered down
    assign detected = lowSync & state_reg.detOn;

    // Any drop of the status restarts the count, so chatter near the threshold cannot
    // shorten the delay
    lvm_delay u_flagDelay (
        .mclk      (mclk),
        .rst       (rst),
        .run       (detected),
        .limit     (flagLimit),
        .done      (flagDone),
        .donePulse (flagRise)
    );

    // Settle only reports readiness; software decides when to trust the status
    lvm_delay u_settle (
        .mclk      (mclk),
        .rst       (rst),
        .run       (state_reg.detOn),
        .limit     (settleLimit),
        .done      (settled),
        .donePulse ()
    );

    // APB decode
    assign setupPhase = psel & ~penable;
    assign writeTaken = psel & penable & pwrite & state_reg.ready;
    assign hitCtrl    = (paddr == ADDR_CTRL);
    assign hitIrq     = (paddr == ADDR_IRQ);

    always_comb begin
        ctrlRead                                  = CTRL_RESET;
        ctrlRead[CTRL_SEL_LSB +: CTRL_SEL_W]      = state_reg.sel;
        ctrlRead[CTRL_REF_BIT]                    = state_reg.refBit;
        ctrlRead[CTRL_EN_BIT]                     = state_reg.enBit;
        ctrlRead[CTRL_DET_BIT]                    = detected;
        irqRead                                   = IRQ_RESET;
        irqRead[IRQ_GIE_BIT]                      = state_reg.gie;
        irqRead[IRQ_LVIEN_BIT]                    = state_reg.lvIrqEn;
        irqRead[IRQ_MFE_BIT]                      = state_reg.mfe;
        irqRead[IRQ_LVREQ_BIT]                    = state_reg.lvReq;
        irqRead[IRQ_MFF_BIT]                      = state_reg.mff;
        irqRead[IRQ_SETTLE_BIT]                   = settled;
    end

    always_comb begin
        state_next        = state_reg;
        state_next.ready  = setupPhase;
        state_next.pushPc = 1'b0;
        state_next.wake   = 1'b0;

        // Read data and error are prepared in the setup cycle for a zero-wait access
        if (setupPhase) begin
            state_next.slverr = ~(hitCtrl | hitIrq);
            if (hitCtrl) begin
                state_next.rdata = {24'h000000, ctrlRead};
            end else if (hitIrq) begin
                state_next.rdata = {24'h000000, irqRead};
            end else begin
                state_next.rdata = 32'h00000000;
            end
        end

        // Software writes; bit 5 of control is read-only
        if (writeTaken && !state_reg.slverr) begin
            if (hitCtrl) begin
                state_next.sel    = pwdata[CTRL_SEL_LSB +: CTRL_SEL_W];
                state_next.refBit = pwdata[CTRL_REF_BIT];
                state_next.enBit  = pwdata[CTRL_EN_BIT];
            end else if (hitIrq) begin
                state_next.gie = pwdata[IRQ_GIE_BIT];
                state_next.lvIrqEn = pwdata[IRQ_LVIEN_BIT];
                state_next.mfe     = pwdata[IRQ_MFE_BIT];
                state_next.lvReq   = pwdata[IRQ_LVREQ_BIT];
                state_next.mff = pwdata[IRQ_MFF_BIT];
            end
        end

        // Return instructions
        if (retReenable) begin
            state_next.gie = 1'b1;
        end

        // Vector taken: core stacks the PC only; the source flag is left for software
        if (serviceAck && state_reg.vecReq) begin
            state_next.gie    = 1'b0;
            state_next.mff    = 1'b0;
            state_next.pushPc = 1'b1;
        end

        // Hardware sets come last so a same-cycle clear cannot lose an event
        if (flagRise) begin
            state_next.lvReq = 1'b1;
        end
        if ((flagRise && state_reg.lvIrqEn) || otherSourceRise) begin
            state_next.mff = 1'b1;
        end

        // Sleep gates the detector whatever the enable bit says
        state_next.detOn = state_next.enBit & ~sleepMode;
        state_next.refOn = state_next.enBit | lowResetOn | state_next.refBit;
        state_next.senseExt = (state_next.sel == SEL_EXTERNAL);

        // Run length of the detected status, kept only for the delay check
        if (!detected) begin
            state_next.detRun = '0;
        end else if (state_reg.detRun != {CNT_W{1'b1}}) begin
            state_next.detRun = state_reg.detRun + 1'b1;
        end

        // Low voltage reaches the vector only through the combined flag, set under its enable
        state_next.vecReq = state_next.gie & state_next.mfe & state_next.mff & ~stackFull
                          & ~(serviceAck & state_reg.vecReq);

        // Wake-up ignores every enable bit
        if ((sleepMode || idleMode)
            && ((state_next.lvReq && !state_reg.lvReq) || (state_next.mff && !state_reg.mff))) begin
            state_next.wake = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= '{senseExt: 1'b1, default: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flip-flops
    assign prdata        = state_reg.rdata;
    assign pready        = state_reg.ready;
    assign pslverr       = state_reg.slverr;
    assign detectorOn    = state_reg.detOn;
    assign referenceOn   = state_reg.refOn;
    assign thresholdSel  = state_reg.sel;
    assign senseExternal = state_reg.senseExt;
    assign vectorRequest = state_reg.vecReq;
    assign pushPcOnly    = state_reg.pushPc;
    assign wakeUp        = state_reg.wake;

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    vector_gating_a: assert property (
        vectorRequest |-> $past(stackFull) == 1'b0 && state_reg.gie && state_reg.mfe && state_reg.mff)
        else $error("vector request without all enables");

    service_clear_a: assert property (
        serviceAck && vectorRequest && !retReenable |=> !state_reg.gie)
        else $error("service left global enable set");

    service_keeps_flag_a: assert property (
        serviceAck && vectorRequest && state_reg.lvReq && !writeTaken |=> state_reg.lvReq)
        else $error("service cleared the low-voltage flag");

    flag_delay_a: assert property (
        $rose(state_reg.lvReq) && !$past(writeTaken) |-> $past(detected, 2))
        else $error("flag set without detected status");

    reenable_sets_a: assert property (
        retReenable && !serviceAck |=> state_reg.gie)
        else $error("return did not reenable");

    sleep_off_a: assert property (
        sleepMode |=> !detectorOn)
        else $error("detector on in sleep");

    ref_enable_a: assert property (
        lowResetOn |=> referenceOn)
        else $error("reference off with reset monitor on");

    wake_rise_a: assert property (
        idleMode && flagRise && !state_reg.lvReq |=> wakeUp)
        else $error("no wake-up on flag rise");

    push_once_a: assert property (
        pushPcOnly |-> $past(serviceAck) ##1 !pushPcOnly)
        else $error("push outside a service");

    unmapped_err_a: assert property (
        psel && !penable && !hitCtrl && !hitIrq |=> pslverr && pready && prdata == 32'h00000000)
        else $error("unmapped access not refused");

    vector_drop_a: assert property (
        serviceAck && vectorRequest |=> !vectorRequest)
        else $error("vector request held after service");

    ret_keeps_a: assert property (
        retInstr && !retReenable && !writeTaken && !(serviceAck && vectorRequest)
        |=> state_reg.gie == $past(state_reg.gie))
        else $error("plain return changed global enable");

    delay_count_a: assert property (
        flagRise |-> state_reg.detRun == flagLimit)
        else $error("flag delay not counted in full");

    flag_hold_a: assert property (
        state_reg.lvReq && !writeTaken |=> state_reg.lvReq)
        else $error("request flag dropped without a write");

    flag_set_a: assert property (
        flagRise |=> state_reg.lvReq)
        else $error("low voltage did not set the flag");

    combined_set_a: assert property (
        otherSourceRise |=> state_reg.mff)
        else $error("combined flag not set by source");

    wake_combined_a: assert property (
        (sleepMode || idleMode) && otherSourceRise && !state_reg.mff |=> wakeUp)
        else $error("no wake-up on combined flag rise");

    sense_code_a: assert property (
        senseExternal == (thresholdSel == SEL_EXTERNAL))
        else $error("external sense does not match code");

    ctrl_write_a: assert property (
        writeTaken && hitCtrl && !state_reg.slverr
        |=> thresholdSel == $past(pwdata[CTRL_SEL_LSB +: CTRL_SEL_W]))
        else $error("threshold write lost");

    det_power_a: assert property (
        !state_reg.enBit && !writeTaken |=> !detectorOn)
        else $error("detector on while disabled");

    ref_bit_a: assert property (
        state_reg.refBit && !writeTaken |=> referenceOn)
        else $error("reference off with its bit set");

    status_gate_a: assert property (
        !state_reg.detOn |-> !ctrlRead[CTRL_DET_BIT])
        else $error("status reads low voltage with detector off");
endmodule // lvm_top

// ==== verification/tb_lvm_top.sv ====
// Self-checking bench for the low-voltage monitor: register map, detection delay, interrupt and wake-up.
// Assumes lvm_top with a zero-wait APB slave on mclk and shortened delay parameters.
`timescale 1ns/100ps
module tb_lvm_top
    import lvm_pkg::*;
;
    localparam int unsigned FLAG = 8;
    localparam int unsigned SETL = 10;
    logic        mclk, rst, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, comparatorLow, detectorOn, referenceOn, senseExternal;
    logic [2:0]  thresholdSel;
    logic        lowResetOn, sleepMode, idleMode, stackFull, serviceAck, retInstr, retReenable;
    logic        otherSourceRise, vectorRequest, pushPcOnly, wakeUp;
    logic [32:0] expQ[$];
    logic [11:0] tab[5];
    int          n_mismatch, n_tests, rnd, n, w;
    int          nWake = 0;

    lvm_top #(.FLAG_CYCLES(FLAG), .SETTLE_CYCLES(SETL)) i_dut (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .comparatorLow(comparatorLow), .detectorOn(detectorOn), .referenceOn(referenceOn),
        .thresholdSel(thresholdSel), .senseExternal(senseExternal), .lowResetOn(lowResetOn),
        .sleepMode(sleepMode), .idleMode(idleMode), .stackFull(stackFull), .serviceAck(serviceAck),
        .retInstr(retInstr), .retReenable(retReenable), .otherSourceRise(otherSourceRise),
        .vectorRequest(vectorRequest), .pushPcOnly(pushPcOnly), .wakeUp(wakeUp)
    );

    always #2 mclk = ~mclk;

    task automatic chkBit(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic chkWord(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    // Read data is judged here so the driver never looks at its own answers
    always @(posedge mclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            chkWord("prdata", expQ[0][31:0], prdata);
            chkBit("pslverr", expQ[0][32], pslverr);
            void'(expQ.pop_front());
        end
        if (wakeUp === 1'b1) begin
            nWake <= nWake + 1;
        end
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        expQ.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
    endtask

    task automatic endTest(input string nm);
        $display("Test %s finished, mismatches so far %0d", nm, n_mismatch);
    endtask

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        cyc(4000);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        {mclk, psel, penable, pwrite, comparatorLow, lowResetOn, sleepMode, idleMode} = 8'h00;
        {stackFull, serviceAck, retInstr, retReenable, otherSourceRise} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        rst = 1'b1;
        n_mismatch = 0;
        n_tests = 0;
        // Entries: reset monitor, sleep, expected reference, expected detector power, control value
        tab = '{12'h208, 12'hA00, 12'h310, 12'h610, 12'h000};
        rnd = $urandom(32'h6856DA30);
        cyc(2);
        rst <= 1'b0;
        @(posedge mclk);
        rd(ADDR_CTRL, {25'h0, CTRL_RESET});
        rd(ADDR_IRQ, {25'h0, IRQ_RESET});
        rd(12'h008, 33'h100000000);
        endTest("reset");
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_CTRL, ($urandom() & 32'hFFFFFFC0) | 32'h20 | 32'(c));
            rd(ADDR_CTRL, {25'h0, 8'(c)});
            chkWord("thresholdSel", 32'(c), {29'h0, thresholdSel});
            chkBit("senseExternal", c == 0, senseExternal);
        end
        foreach (tab[i]) begin
            lowResetOn <= tab[i][11];
            sleepMode  <= tab[i][10];
            wr(ADDR_CTRL, {24'h0, tab[i][7:0]});
            cyc(2);
            chkBit("referenceOn", tab[i][9], referenceOn);
            chkBit("detectorOn", tab[i][8], detectorOn);
        end
        endTest("control");
        wr(ADDR_CTRL, 32'h11);
        wr(ADDR_IRQ, 32'h07);
        idleMode <= 1'b1;
        cyc(SETL + 10);
        w = nWake;
        repeat (3) begin
            comparatorLow <= 1'b1;
            cyc(FLAG - 2);
            comparatorLow <= 1'b0;
            cyc(4);
        end
        cyc(30);
        rd(ADDR_IRQ, 33'h27);
        chkBit("wakeUp seen", 1'b0, nWake != w);
        endTest("toggle");
        comparatorLow <= 1'b1;
        cyc(4);
        rd(ADDR_CTRL, 33'h31);
        n = 0;
        while (vectorRequest !== 1'b1 && n < 40) begin
            @(posedge mclk);
            n++;
        end
        chkBit("vectorRequest", 1'b1, vectorRequest);
        comparatorLow <= 1'b0;
        cyc(1);
        chkBit("wakeUp seen", 1'b1, nWake != w);
        rd(ADDR_IRQ, 33'h3F);
        serviceAck <= 1'b1;
        @(posedge mclk);
        serviceAck <= 1'b0;
        @(posedge mclk);
        chkBit("pushPcOnly", 1'b1, pushPcOnly);
        chkBit("vectorRequest", 1'b0, vectorRequest);
        rd(ADDR_IRQ, 33'h2E);
        retInstr <= 1'b1;
        @(posedge mclk);
        retInstr <= 1'b0;
        @(posedge mclk);
        rd(ADDR_IRQ, 33'h2E);
        retReenable <= 1'b1;
        @(posedge mclk);
        retReenable <= 1'b0;
        @(posedge mclk);
        rd(ADDR_IRQ, 33'h2F);
        wr(ADDR_IRQ, 32'h07);
        rd(ADDR_IRQ, 33'h27);
        endTest("service");
        stackFull <= 1'b1;
        otherSourceRise <= 1'b1;
        @(posedge mclk);
        otherSourceRise <= 1'b0;
        cyc(3);
        chkBit("vectorRequest", 1'b0, vectorRequest);
        rd(ADDR_IRQ, 33'h37);
        stackFull <= 1'b0;
        cyc(2);
        chkBit("vectorRequest", 1'b1, vectorRequest);
        wr(ADDR_IRQ, 32'h00);
        endTest("stack");
        // Presetting the flag is how software suppresses the idle wake-up
        wr(ADDR_IRQ, 32'h08);
        cyc(2);
        w = nWake;
        comparatorLow <= 1'b1;
        cyc(FLAG + 20);
        comparatorLow <= 1'b0;
        chkBit("wakeUp seen", 1'b0, nWake != w);
        endTest("preset");
        report_and_stop();
    end
endmodule // tb_lvm_top
